// ---- rtl/tlv_irq_unit.sv ----
`default_nettype none
module tlv_irq_unit
	import tlv_pkg::*;
(
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire tlv_flags_t FLAGS_IN,
	input wire logic INSN_DONE_IN,
	input wire logic RETURN_DONE_IN,
	output logic VECTOR_REQ_OUT,
	output logic [15:0] VECTOR_ADDR_OUT,
	output logic [11:0] FLAG_CLEAR_OUT,
	output logic [1:0] IN_SERVICE_OUT
);
	logic [7:0] enable_reg;
	logic [7:0] priority_reg;
	logic [7:0] ext_enable_reg;
	logic [7:0] ext_priority_reg;
	logic [1:0] in_service_reg;
	logic [11:0] req_sample_reg;
	tlv_state_t state_reg;
	tlv_state_t state_next;
	logic [2:0] call_cnt_reg;
	tlv_pick_t pick_reg;
	tlv_pick_t pick;
	logic [11:0] raw_req;
	logic [11:0] src_en;
	logic [11:0] src_high;
	logic access;
	logic [31:0] rd_next;
	logic mapped;

	// vector address for a source index
	function automatic logic [15:0] vector_of(input logic [3:0] idx);
		return VECTOR_BASE + 16'({idx, 3'b000});
	endfunction

	// merge multi-flag sources into one request line
	always_comb
	begin
		raw_req = {FLAGS_IN.cmp_rise, FLAGS_IN.cmp_fall,
			|FLAGS_IN.counter_array, FLAGS_IN.conv, FLAGS_IN.window,
			FLAGS_IN.bus, |FLAGS_IN.t2, |FLAGS_IN.serial,
			FLAGS_IN.timer1, FLAGS_IN.ext1, FLAGS_IN.timer0,
			FLAGS_IN.ext0};
	end

	// enables and priorities per source
	assign src_en = {ext_enable_reg[5:0], enable_reg[5:0]}
		& {NSRC{enable_reg[GLOBAL_EN_BIT]}};
	assign src_high = {ext_priority_reg[5:0], priority_reg[5:0]};

	// sample requests each clock
	always_ff @(posedge MCLK_IN)
	begin
		if (RST_IN)
			req_sample_reg <= 12'h000;
		else
			req_sample_reg <= raw_req & src_en;
	end

	tlv_arbiter u_arb (
		.req_in(req_sample_reg),
		.high_in(src_high),
		.high_busy_in(in_service_reg[1]),
		.low_busy_in(in_service_reg[0]),
		.pick_out(pick)
	);

	// sequencer: detect, wait instruction boundary, call
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				// first instruction done after a return may take the call
				if (pick.valid && INSN_DONE_IN && !RETURN_DONE_IN)
					state_next = ST_CALL;
			ST_CALL:
				if (call_cnt_reg == CALL_LAST)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK_IN)
	begin
		if (RST_IN)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// latch winner and count call cycles
	always_ff @(posedge MCLK_IN)
	begin
		if (RST_IN)
		begin
			pick_reg <= '0;
			call_cnt_reg <= 3'h0;
		end
		else if (state_reg == ST_IDLE)
		begin
			pick_reg <= pick;
			call_cnt_reg <= 3'h0;
		end
		else
			call_cnt_reg <= call_cnt_reg + 3'h1;
	end

	// vector outputs, held for the call
	always_ff @(posedge MCLK_IN)
	begin
		if (RST_IN)
		begin
			VECTOR_REQ_OUT <= 1'b0;
			VECTOR_ADDR_OUT <= RESET_VECTOR;
		end
		else if (state_next == ST_CALL)
		begin
			VECTOR_REQ_OUT <= 1'b1;
			VECTOR_ADDR_OUT <= vector_of(state_reg == ST_IDLE
				? pick.index : pick_reg.index);
		end
		else
			VECTOR_REQ_OUT <= 1'b0;
	end

	// auto clear pulse for the four simple sources
	always_ff @(posedge MCLK_IN)
	begin
		if (RST_IN)
			FLAG_CLEAR_OUT <= 12'h000;
		else if (state_reg == ST_IDLE && state_next == ST_CALL)
			FLAG_CLEAR_OUT <= (12'h001 << pick.index)
				& AUTO_CLEAR_MASK;
		else
			FLAG_CLEAR_OUT <= 12'h000;
	end

	// in-service bits per level
	always_ff @(posedge MCLK_IN)
	begin
		if (RST_IN)
			in_service_reg <= 2'b00;
		else if (state_reg == ST_IDLE && state_next == ST_CALL)
		begin
			if (pick.high)
				in_service_reg[1] <= 1'b1;
			else
				in_service_reg[0] <= 1'b1;
		end
		else if (RETURN_DONE_IN)
		begin
			if (in_service_reg[1])
				in_service_reg[1] <= 1'b0;
			else
				in_service_reg[0] <= 1'b0;
		end
	end

	assign IN_SERVICE_OUT = in_service_reg;

	// apb decode, zero wait states
	assign access = PSEL_IN && PENABLE_IN;
	always_comb
	begin
		rd_next = 32'h0000_0000;
		mapped = 1'b1;
		case (PADDR_IN)
			ADDR_ENABLE: rd_next = {24'h000000, enable_reg};
			ADDR_PRIORITY:
				rd_next = {24'h000000,
					priority_reg | PRIORITY_TOP_ONES};
			ADDR_EXT_ENABLE:
				rd_next = {24'h000000, 2'b00, ext_enable_reg[5:0]};
			ADDR_EXT_PRIORITY:
				rd_next = {24'h000000,
					ext_priority_reg | PRIORITY_TOP_ONES};
			ADDR_STATUS:
				rd_next = {16'h0000, 2'b00, in_service_reg,
					req_sample_reg};
			default: mapped = 1'b0;
		endcase
	end

	// register writes
	always_ff @(posedge MCLK_IN)
	begin
		if (RST_IN)
		begin
			enable_reg <= ENABLE_RESET;
			priority_reg <= PRIORITY_RESET;
			ext_enable_reg <= EXT_ENABLE_RESET;
			ext_priority_reg <= EXT_PRIORITY_RESET;
		end
		else if (access && PWRITE_IN)
		begin
			case (PADDR_IN)
				ADDR_ENABLE: enable_reg <= PWDATA_IN[7:0];
				ADDR_PRIORITY:
					priority_reg <= {2'b11, PWDATA_IN[5:0]};
				ADDR_EXT_ENABLE:
					ext_enable_reg <= {2'b00, PWDATA_IN[5:0]};
				ADDR_EXT_PRIORITY:
					ext_priority_reg <= {2'b11, PWDATA_IN[5:0]};
				default: ;
			endcase
		end
	end

	// apb answer registers
	always_ff @(posedge MCLK_IN)
	begin
		if (RST_IN)
		begin
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
		end
		else
		begin
			PREADY_OUT <= PSEL_IN && !PENABLE_IN;
			PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !mapped;
			PRDATA_OUT <= (PSEL_IN && !PENABLE_IN) ? rd_next : 32'h0;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/tlv_pkg.sv ----
// Operation
// - pending requests sampled and arbitrated every clock; vector call after detection.
// - request pending at return lets exactly one more instruction finish first.
// - worst case eighteen cycles: detect, return, divide, vector call.
// - equal or lower priority waits for routine end plus one instruction.
// - reset vector 0x0000; sources at 0x0003 plus eight times index.
// - hardware clears only ext0, timer0, ext1, timer1 flags on vectoring.
// - multi-flag sources raise one request when any flag is set.
// - global enable bit 7 gates every source.
// - enable bits 0..5 mask ext0, timer0, ext1, timer1, serial, timer2.
// - enable bit 6 is a spare software flag only.
// - priority bits 0..5 select high level when one.
// - priority bits 7..6 read ones, writes ignored.
// - extended enable bits 0..5 mask sources 6..11; top bits read zero.
// - flags set regardless of enable; disabled flags ignored.
// - high preempts low; high never preempted.
// - flag still set after return re-requests after next instruction.
`default_nettype none
package tlv_pkg;
	localparam int NSRC = 12;
	localparam logic [11:0] ADDR_ENABLE = 12'h0A8;
	localparam logic [11:0] ADDR_PRIORITY = 12'h0B8;
	localparam logic [11:0] ADDR_EXT_ENABLE = 12'h0E6;
	localparam logic [11:0] ADDR_EXT_PRIORITY = 12'h0F6;
	localparam logic [11:0] ADDR_STATUS = 12'h100;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] PRIORITY_RESET = 8'hC0;
	localparam logic [7:0] EXT_ENABLE_RESET = 8'h00;
	localparam logic [7:0] EXT_PRIORITY_RESET = 8'hC0;
	localparam logic [7:0] PRIORITY_TOP_ONES = 8'hC0;
	localparam int GLOBAL_EN_BIT = 7;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam int VECTOR_STRIDE_SHIFT = 3;
	localparam logic [11:0] AUTO_CLEAR_MASK = 12'h00F;
	localparam int DETECT_CYCLES = 1;
	localparam int CALL_CYCLES = 4;
	localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);
	typedef struct packed {
		logic [1:0] t2;
		logic [1:0] serial;
		logic [4:0] counter_array;
		logic ext0, timer0, ext1, timer1;
		logic bus, window, conv, cmp_fall, cmp_rise;
	} tlv_flags_t;
	typedef struct packed {
		logic valid;
		logic high;
		logic [3:0] index;
	} tlv_pick_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALL = 2'b01,
		ST_HOLD = 2'b10
	} tlv_state_t;
endpackage
`default_nettype wire

// ---- rtl/tlv_arbiter.sv ----
`default_nettype none
module tlv_arbiter
	import tlv_pkg::*;
(
	input wire logic [11:0] req_in,
	input wire logic [11:0] high_in,
	input wire logic high_busy_in,
	input wire logic low_busy_in,
	output tlv_pick_t pick_out
);
	logic [11:0] hi_req;
	logic [11:0] lo_req;
	// lowest index wins inside a level
	function automatic logic [4:0] first_set(input logic [11:0] v);
		logic [4:0] r;
		r = 5'h1F;
		for (int i = NSRC - 1; i >= 0; i--)
		begin
			if (v[i])
				r = {1'b0, 4'(i)};
		end
		return r;
	endfunction
	// high level preempts low; high routine blocks all
	always_comb
	begin
		logic [4:0] fh;
		logic [4:0] fl;
		fh = 5'h1F;
		fl = 5'h1F;
		hi_req = high_busy_in ? 12'h000 : (req_in & high_in);
		lo_req = (high_busy_in || low_busy_in) ? 12'h000
			: (req_in & ~high_in);
		fh = first_set(hi_req);
		fl = first_set(lo_req);
		pick_out = '0;
		if (|hi_req)
			pick_out = '{valid: 1'b1, high: 1'b1, index: fh[3:0]};
		else if (|lo_req)
			pick_out = '{valid: 1'b1, high: 1'b0, index: fl[3:0]};
	end
endmodule
`default_nettype wire

// ---- verification/tlv_irq_unit_sva.sv ----
`default_nettype none
module tlv_irq_unit_sva
(
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic INSN_DONE_IN,
	input wire logic RETURN_DONE_IN,
	input wire logic VECTOR_REQ_OUT,
	input wire logic [15:0] VECTOR_ADDR_OUT,
	input wire logic [11:0] FLAG_CLEAR_OUT,
	input wire logic [1:0] IN_SERVICE_OUT
);
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (RST_IN);
	// call start and its four-cycle body
	sequence s_start;
		$rose(VECTOR_REQ_OUT);
	endsequence
	sequence s_call;
		VECTOR_REQ_OUT [*4] ##1 !VECTOR_REQ_OUT;
	endsequence
	property p_call; s_start |-> s_call; endproperty
	a_call: assert property (p_call) else $error("call length");
	property p_go; s_start |-> $past(INSN_DONE_IN); endproperty
	a_go: assert property (p_go) else $error("call without insn");
	property p_vec;
		VECTOR_REQ_OUT |-> VECTOR_ADDR_OUT[2:0] == 3'h3
			&& VECTOR_ADDR_OUT <= 16'h005B;
	endproperty
	a_vec: assert property (p_vec) else $error("vector addr");
	property p_clr; FLAG_CLEAR_OUT != 12'h000 |-> s_start; endproperty
	a_clr: assert property (p_clr) else $error("stray clear");
	property p_auto;
		s_start |-> FLAG_CLEAR_OUT == ((VECTOR_ADDR_OUT[6:3] < 4'h4)
			? 12'h001 << VECTOR_ADDR_OUT[6:3] : 12'h000);
	endproperty
	a_auto: assert property (p_auto) else $error("clear mask");
	property p_ret; RETURN_DONE_IN |=> !$rose(VECTOR_REQ_OUT); endproperty
	a_ret: assert property (p_ret) else $error("call after return");
	property p_srv; s_start |-> IN_SERVICE_OUT != 2'h0; endproperty
	a_srv: assert property (p_srv) else $error("no in-service");
	property p_high;
		IN_SERVICE_OUT[1] && !RETURN_DONE_IN |=> !$rose(VECTOR_REQ_OUT);
	endproperty
	a_high: assert property (p_high) else $error("high preempted");
endmodule
`default_nettype wire

// ---- verification/tlv_core_model.sv ----
`default_nettype none
module tlv_core_model
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ret_in,
	input wire logic [3:0] gap_in,
	output logic insn_out,
	output logic ret_out
);
	logic [3:0] cnt_reg;
	logic pend_reg;
	logic slot;
	assign slot = cnt_reg >= gap_in;
	// an instruction ends each gap_in+1 cycles; a return takes one slot
	always_ff @(posedge clk_in)
	begin
		cnt_reg <= (rst_in || slot) ? 4'h0 : cnt_reg + 4'h1;
		pend_reg <= !rst_in && (ret_in || (pend_reg && !slot));
		insn_out <= !rst_in && slot && !pend_reg;
		ret_out <= !rst_in && slot && pend_reg;
	end
endmodule
`default_nettype wire

// ---- verification/tlv_irq_unit_tb_top.sv ----
`default_nettype none
module tlv_irq_unit_tb_top
	import tlv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic ret = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] gap = 4'h0;
	tlv_flags_t flags = 18'h00000;
	logic [31:0] prdata;
	logic pready, pslverr, insn, retd, vreq, e;
	logic [15:0] vaddr;
	logic [11:0] fclr;
	logic [1:0] insv;
	logic [7:0] q;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int nvec = 0;
	int n;
	always #25 clk = ~clk;
	tlv_irq_unit u_dut (.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .FLAGS_IN(flags), .INSN_DONE_IN(insn),
		.RETURN_DONE_IN(retd), .VECTOR_REQ_OUT(vreq),
		.VECTOR_ADDR_OUT(vaddr), .FLAG_CLEAR_OUT(fclr),
		.IN_SERVICE_OUT(insv));
	tlv_core_model u_core (.clk_in(clk), .rst_in(rst), .ret_in(ret),
		.gap_in(gap), .insn_out(insn), .ret_out(retd));
	task automatic close_out();
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is taken
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		pen <= 1'b1;
		// answer and read data taken at the edge that sees pready
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(a, 1'b0, 8'h00);
		chk({8'h00, q}, {8'h00, x});
		chk({15'h0000, e}, 16'h0000);
	endtask
	// wait for a call, check it, let it finish
	task automatic vec(input logic [15:0] a, input logic [11:0] c);
		n = 0;
		@(negedge clk);
		while (vreq !== 1'b1)
		begin
			n++;
			@(negedge clk);
		end
		chk(vaddr, a);
		chk({4'h0, fclr}, {4'h0, c});
		while (vreq === 1'b1)
			@(negedge clk);
		@(posedge clk);
	endtask
	task automatic rti();
		@(posedge clk);
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
		@(negedge clk);
		while (retd !== 1'b1)
			@(negedge clk);
		@(posedge clk);
	endtask
	// call counter and hang guard
	always @(posedge vreq)
		nvec++;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			close_out();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_ENABLE, 8'h00);
		rd(ADDR_PRIORITY, 8'hC0);
		wr(ADDR_PRIORITY, 8'h00);
		rd(ADDR_PRIORITY, 8'hC0);
		wr(ADDR_EXT_ENABLE, 8'hFF);
		rd(ADDR_EXT_ENABLE, 8'h3F);
		apb(12'h0FC, 1'b0, 8'h00);
		chk({15'h0000, e}, 16'h0001);
		flags.ext0 <= 1'b1;
		wr(ADDR_EXT_ENABLE, 8'h00);
		wr(ADDR_ENABLE, 8'h41);
		rd(ADDR_ENABLE, 8'h41);
		chk(16'(nvec), 16'h0000);
		wr(ADDR_ENABLE, 8'h81);
		vec(16'h0003, 12'h001);
		chk({15'h0000, n < 3}, 16'h0001);
		flags <= 18'h00000;
		flags.timer0 <= 1'b1;
		flags.ext1 <= 1'b1;
		wr(ADDR_PRIORITY, 8'h02);
		wr(ADDR_ENABLE, 8'h87);
		vec(16'h000B, 12'h002);
		chk({14'h0000, insv}, 16'h0003);
		flags.timer0 <= 1'b0;
		rti();
		repeat (6) @(negedge clk);
		chk(16'(nvec), 16'h0002);
		chk({14'h0000, insv}, 16'h0001);
		rti();
		vec(16'h0013, 12'h004);
		flags.ext1 <= 1'b0;
		rti();
		flags.cmp_rise <= 1'b1;
		wr(ADDR_EXT_ENABLE, 8'h20);
		wr(ADDR_ENABLE, 8'h80);
		vec(16'h005B, 12'h000);
		gap <= 4'h7;
		rti();
		vec(16'h005B, 12'h000);
		chk({15'h0000, n > 6 && n < 10}, 16'h0001);
		flags.cmp_rise <= 1'b0;
		rti();
		gap <= 4'h0;
		flags.serial <= 2'b01;
		flags.t2 <= 2'b10;
		wr(ADDR_ENABLE, 8'hB0);
		vec(16'h0023, 12'h000);
		flags.serial <= 2'b00;
		rti();
		vec(16'h002B, 12'h000);
		close_out();
	end
endmodule
bind tlv_irq_unit tlv_irq_unit_sva u_sva (.MCLK_IN(MCLK_IN),
	.RST_IN(RST_IN), .INSN_DONE_IN(INSN_DONE_IN),
	.RETURN_DONE_IN(RETURN_DONE_IN), .VECTOR_REQ_OUT(VECTOR_REQ_OUT),
	.VECTOR_ADDR_OUT(VECTOR_ADDR_OUT), .FLAG_CLEAR_OUT(FLAG_CLEAR_OUT),
	.IN_SERVICE_OUT(IN_SERVICE_OUT));
`default_nettype wire
